/* common/boot_pkg.sv */
package boot_pkg;
	localparam int             ADDR_W          = 24;
	localparam int             WORD_W          = 16;
	localparam logic [4:0]     SAMPLE_CYCLES   = 5'h1e;
	// strap codes
	localparam logic [3:0]     MODE_NOBOOT_A   = 4'h0;
	localparam logic [3:0]     MODE_SPI24      = 4'h1;
	localparam logic [3:0]     MODE_RSV_FIRST  = 4'h2;
	localparam logic [3:0]     MODE_RSV_LAST   = 4'h7;
	localparam logic [3:0]     MODE_NOBOOT_B   = 4'h8;
	localparam logic [3:0]     MODE_SPI16      = 4'h9;
	localparam logic [3:0]     MODE_XMEM8      = 4'ha;
	localparam logic [3:0]     MODE_XMEM16     = 4'hb;
	localparam logic [3:0]     MODE_XMEM32     = 4'hc;
	localparam logic [3:0]     MODE_HOST       = 4'hd;
	localparam logic [3:0]     MODE_SER16      = 4'he;
	localparam logic [3:0]     MODE_SER8       = 4'hf;
	// boot source and option codes
	localparam logic [2:0]     SRC_NONE        = 3'h0;
	localparam logic [2:0]     SRC_SPI         = 3'h1;
	localparam logic [2:0]     SRC_XMEM        = 3'h2;
	localparam logic [2:0]     SRC_HOST        = 3'h3;
	localparam logic [2:0]     SRC_SERIAL      = 3'h4;
	localparam logic [2:0]     SRC_RESERVED    = 3'h7;
	localparam logic [1:0]     OPT_SPI_ADDR16  = 2'h0;
	localparam logic [1:0]     OPT_SPI_ADDR24  = 2'h1;
	localparam logic [1:0]     OPT_WIDTH8      = 2'h0;
	localparam logic [1:0]     OPT_WIDTH16     = 2'h1;
	localparam logic [1:0]     OPT_WIDTH32     = 2'h2;
	// processor state values
	localparam logic [23:0]    DATA_STACK_INIT = 24'h000090;
	localparam logic [23:0]    SYS_STACK_INIT  = 24'h000080;
	localparam logic [1:0]     STACK_32_SLOW   = 2'h0;
	localparam logic [23:0]    SCRATCH_HI_ADDR = 24'h000060;
	localparam logic [23:0]    SCRATCH_LO_ADDR = 24'h000061;
	// address map
	localparam logic [23:0]    ROM_BOOT_ADDR   = 24'hff8000;
	localparam logic [23:0]    ROM_SINE_ADDR   = 24'hfffa00;
	localparam logic [23:0]    ROM_VECTOR_ADDR = 24'hffff00;
	localparam logic [23:0]    HOST_ENTRY_ADDR = 24'h010000;
	// boot table port address that means a delay entry
	localparam logic [15:0]    DELAY_MARK      = 16'hffff;
endpackage : boot_pkg

/* logic/delay_timer.sv */
`timescale 1ns/1ps
module delay_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              busy
);
	logic [W-1:0] cnt_r;

	// busy for exactly count cycles after the load edge
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= count;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	assign busy = (cnt_r != '0);
endmodule : delay_timer

/* logic/boot_sequencer.sv */
`timescale 1ns/1ps
module boot_sequencer
	import boot_pkg::*;
#(
	parameter logic [23:0] CS3_VECTOR_ADDR = 24'hffff00,
	parameter int          DELAY_W         = 16
) (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              RESET,
	// boot mode straps
	input  wire logic              GP_LINE_ONE_IN,
	input  wire logic              GP_LINE_TWO_IN,
	input  wire logic              GP_LINE_THREE_IN,
	input  wire logic              BOOT_SOURCE_STRAPS_BIT3,
	// handshake pin
	output logic                   BOOT_HANDSHAKE_LINE_OUT,
	output logic                   BOOT_HANDSHAKE_LINE_OE_N,
	// host port
	input  wire logic              HOST_RESET_FLAG,
	// boot table word stream
	input  wire logic              TABLE_VALID,
	input  wire logic [WORD_W-1:0] TABLE_DATA,
	output logic                   TABLE_READY,
	// selected source
	output logic [3:0]             MODE_CODE,
	output logic [2:0]             BOOT_SOURCE,
	output logic [1:0]             SOURCE_OPTION,
	output logic                   ROM_MAPPED,
	// processor state
	output logic [ADDR_W-1:0]      DATA_STACK_POINTER,
	output logic [ADDR_W-1:0]      SYSTEM_STACK_POINTER,
	output logic [1:0]             STACK_MODE,
	output logic                   GLOBAL_INTERRUPT_MASK,
	output logic                   SIGN_EXTENSION_MODE,
	output logic                   LEGACY_COMPAT_MODE,
	// memory writes
	output logic                   MEM_WR,
	output logic [ADDR_W-1:0]      MEM_ADDR,
	output logic [WORD_W-1:0]      MEM_DATA,
	// port register writes
	output logic                   PORT_WR,
	output logic [WORD_W-1:0]      PORT_ADDR,
	output logic [WORD_W-1:0]      PORT_DATA,
	// execution
	output logic [ADDR_W-1:0]      PC_ADDR,
	output logic                   EXEC_VALID,
	output logic                   BOOT_HALTED
);
	typedef enum logic [3:0] {
		ST_WAIT, ST_INIT, ST_ENTRY_HI, ST_ENTRY_LO, ST_CFG_CNT, ST_CFG_ADDR,
		ST_CFG_DATA, ST_DELAY, ST_SEC_LEN, ST_DEST_HI, ST_DEST_LO, ST_SEC_DATA,
		ST_HOST_POLL, ST_FINISH, ST_RUN, ST_HALT
	} boot_state_e;

	boot_state_e         state_r;
	boot_state_e         state_nxt;
	logic [4:0]          samp_cnt_r;
	logic                sampled_r;
	logic [ADDR_W-1:0]   entry_r;
	logic [WORD_W-1:0]   cfg_cnt_r;
	logic [WORD_W-1:0]   port_addr_r;
	logic [WORD_W-1:0]   sec_len_r;
	logic [ADDR_W-1:0]   dest_r;
	logic                accept;
	logic                sample_now;
	logic                delay_load;
	logic                delay_busy;
	logic                is_noboot;
	logic                is_host;
	logic                is_reserved;
	logic                table_mode_r;

	assign accept      = TABLE_VALID & TABLE_READY;
	assign sample_now  = (state_r == ST_WAIT) && (samp_cnt_r == SAMPLE_CYCLES - 5'h01);
	assign is_noboot   = (MODE_CODE == MODE_NOBOOT_A) || (MODE_CODE == MODE_NOBOOT_B);
	assign is_host     = (MODE_CODE == MODE_HOST);
	assign is_reserved = (MODE_CODE >= MODE_RSV_FIRST) && (MODE_CODE <= MODE_RSV_LAST);
	assign delay_load  = (state_r == ST_CFG_DATA) && accept && (port_addr_r == DELAY_MARK);

	delay_timer #(
		.W (DELAY_W)
	) u_delay (
		.clk   (CLK),
		.reset (RESET),
		.load  (delay_load),
		.count (TABLE_DATA[DELAY_W-1:0]),
		.busy  (delay_busy)
	);

	// sequence control; every reset restarts from the sampling wait
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_WAIT: begin
				if (sample_now) state_nxt = ST_INIT;
			end
			ST_INIT: begin
				if (is_noboot) state_nxt = ST_RUN;
				else if (is_reserved) state_nxt = ST_HALT;
				else if (is_host) state_nxt = ST_HOST_POLL;
				else state_nxt = ST_ENTRY_HI;
			end
			ST_ENTRY_HI: begin
				if (accept) state_nxt = ST_ENTRY_LO;
			end
			ST_ENTRY_LO: begin
				if (accept) state_nxt = ST_CFG_CNT;
			end
			ST_CFG_CNT: begin
				if (accept) state_nxt = (TABLE_DATA == '0) ? ST_SEC_LEN : ST_CFG_ADDR;
			end
			ST_CFG_ADDR: begin
				if (accept) state_nxt = ST_CFG_DATA;
			end
			ST_CFG_DATA: begin
				if (accept) begin
					if (port_addr_r == DELAY_MARK) state_nxt = ST_DELAY;
					else if (cfg_cnt_r == WORD_W'(1)) state_nxt = ST_SEC_LEN;
					else state_nxt = ST_CFG_ADDR;
				end
			end
			ST_DELAY: begin
				if (!delay_busy) state_nxt = (cfg_cnt_r == '0) ? ST_SEC_LEN : ST_CFG_ADDR;
			end
			ST_SEC_LEN: begin
				if (accept) state_nxt = (TABLE_DATA == '0) ? ST_FINISH : ST_DEST_HI;
			end
			ST_DEST_HI: begin
				if (accept) state_nxt = ST_DEST_LO;
			end
			ST_DEST_LO: begin
				if (accept) state_nxt = ST_SEC_DATA;
			end
			ST_SEC_DATA: begin
				if (accept && sec_len_r == WORD_W'(1)) state_nxt = ST_SEC_LEN;
			end
			ST_HOST_POLL: begin
				if (HOST_RESET_FLAG) state_nxt = ST_RUN;
			end
			ST_FINISH: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = state_r;
			end
		endcase
	end

	// strap sampling and state register
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_r    <= ST_WAIT;
			samp_cnt_r <= '0;
			sampled_r  <= 1'h0;
			MODE_CODE  <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_WAIT) samp_cnt_r <= samp_cnt_r + 5'h01;
			if (sample_now) begin
				sampled_r <= 1'h1;
				MODE_CODE <= {BOOT_SOURCE_STRAPS_BIT3, GP_LINE_THREE_IN,
				              GP_LINE_TWO_IN, GP_LINE_ONE_IN};
			end
		end
	end

	// source decode, ROM mapping and halt
	always_ff @(posedge CLK) begin
		if (RESET) begin
			BOOT_SOURCE   <= SRC_NONE;
			SOURCE_OPTION <= '0;
			ROM_MAPPED    <= 1'h1;
			BOOT_HALTED   <= 1'h0;
			table_mode_r  <= 1'h0;
		end else begin
			if (state_r == ST_INIT) begin
				table_mode_r <= !is_noboot && !is_host && !is_reserved;
				if (is_noboot) ROM_MAPPED <= 1'h0;
				case (MODE_CODE)
					MODE_NOBOOT_A, MODE_NOBOOT_B: begin
						BOOT_SOURCE <= SRC_NONE;
					end
					MODE_SPI24: begin
						BOOT_SOURCE   <= SRC_SPI;
						SOURCE_OPTION <= OPT_SPI_ADDR24;
					end
					MODE_SPI16: begin
						BOOT_SOURCE   <= SRC_SPI;
						SOURCE_OPTION <= OPT_SPI_ADDR16;
					end
					MODE_XMEM8: begin
						BOOT_SOURCE   <= SRC_XMEM;
						SOURCE_OPTION <= OPT_WIDTH8;
					end
					MODE_XMEM16: begin
						BOOT_SOURCE   <= SRC_XMEM;
						SOURCE_OPTION <= OPT_WIDTH16;
					end
					MODE_XMEM32: begin
						BOOT_SOURCE   <= SRC_XMEM;
						SOURCE_OPTION <= OPT_WIDTH32;
					end
					MODE_HOST: begin
						BOOT_SOURCE <= SRC_HOST;
					end
					MODE_SER16: begin
						BOOT_SOURCE   <= SRC_SERIAL;
						SOURCE_OPTION <= OPT_WIDTH16;
					end
					MODE_SER8: begin
						BOOT_SOURCE   <= SRC_SERIAL;
						SOURCE_OPTION <= OPT_WIDTH8;
					end
					default: begin
						BOOT_SOURCE <= SRC_RESERVED;
					end
				endcase
			end
			BOOT_HALTED <= (state_nxt == ST_HALT);
		end
	end

	// processor state set up by the boot program
	always_ff @(posedge CLK) begin
		if (RESET) begin
			DATA_STACK_POINTER    <= '0;
			SYSTEM_STACK_POINTER  <= '0;
			STACK_MODE            <= STACK_32_SLOW;
			GLOBAL_INTERRUPT_MASK <= 1'h1;
			SIGN_EXTENSION_MODE   <= 1'h1;
			LEGACY_COMPAT_MODE    <= 1'h1;
		end else if (state_r == ST_INIT && !is_noboot) begin
			DATA_STACK_POINTER    <= DATA_STACK_INIT;
			SYSTEM_STACK_POINTER  <= SYS_STACK_INIT;
			STACK_MODE            <= STACK_32_SLOW;
			GLOBAL_INTERRUPT_MASK <= 1'h1;
			SIGN_EXTENSION_MODE   <= 1'h0;
			LEGACY_COMPAT_MODE    <= 1'h1;
		end else if (state_nxt == ST_RUN && state_r != ST_RUN) begin
			SIGN_EXTENSION_MODE <= 1'h1;
		end
	end

	// boot table fields
	always_ff @(posedge CLK) begin
		if (RESET) begin
			entry_r     <= '0;
			cfg_cnt_r   <= '0;
			port_addr_r <= '0;
			sec_len_r   <= '0;
			dest_r      <= '0;
		end else if (accept) begin
			case (state_r)
				ST_ENTRY_HI: entry_r[23:16] <= TABLE_DATA[7:0];
				ST_ENTRY_LO: entry_r[15:0] <= TABLE_DATA;
				ST_CFG_CNT:  cfg_cnt_r <= TABLE_DATA;
				ST_CFG_ADDR: port_addr_r <= TABLE_DATA;
				ST_CFG_DATA: cfg_cnt_r <= cfg_cnt_r - WORD_W'(1);
				ST_SEC_LEN:  sec_len_r <= TABLE_DATA;
				ST_DEST_HI:  dest_r[23:16] <= TABLE_DATA[7:0];
				ST_DEST_LO:  dest_r[15:0] <= TABLE_DATA;
				ST_SEC_DATA: begin
					dest_r    <= dest_r + ADDR_W'(1);
					sec_len_r <= sec_len_r - WORD_W'(1);
				end
				default: begin
				end
			endcase
		end
	end

	// memory and port register writes
	always_ff @(posedge CLK) begin
		if (RESET) begin
			MEM_WR    <= 1'h0;
			MEM_ADDR  <= '0;
			MEM_DATA  <= '0;
			PORT_WR   <= 1'h0;
			PORT_ADDR <= '0;
			PORT_DATA <= '0;
		end else begin
			MEM_WR  <= 1'h0;
			PORT_WR <= 1'h0;
			if (accept && state_r == ST_ENTRY_HI) begin
				MEM_WR   <= 1'h1;
				MEM_ADDR <= SCRATCH_HI_ADDR;
				MEM_DATA <= {8'h00, TABLE_DATA[7:0]};
			end else if (accept && state_r == ST_ENTRY_LO) begin
				MEM_WR   <= 1'h1;
				MEM_ADDR <= SCRATCH_LO_ADDR;
				MEM_DATA <= TABLE_DATA;
			end else if (accept && state_r == ST_SEC_DATA) begin
				MEM_WR   <= 1'h1;
				MEM_ADDR <= dest_r;
				MEM_DATA <= TABLE_DATA;
			end
			if (accept && state_r == ST_CFG_DATA && port_addr_r != DELAY_MARK) begin
				PORT_WR   <= 1'h1;
				PORT_ADDR <= port_addr_r;
				PORT_DATA <= TABLE_DATA;
			end
		end
	end

	// table flow, execution hand-over and handshake pin
	always_ff @(posedge CLK) begin
		if (RESET) begin
			TABLE_READY              <= 1'h0;
			PC_ADDR                  <= ROM_VECTOR_ADDR;
			EXEC_VALID               <= 1'h0;
			BOOT_HANDSHAKE_LINE_OUT  <= 1'h0;
			BOOT_HANDSHAKE_LINE_OE_N <= 1'h1;
		end else begin
			TABLE_READY <= (state_nxt == ST_ENTRY_HI) || (state_nxt == ST_ENTRY_LO) ||
			               (state_nxt == ST_CFG_CNT) || (state_nxt == ST_CFG_ADDR) ||
			               (state_nxt == ST_CFG_DATA) || (state_nxt == ST_SEC_LEN) ||
			               (state_nxt == ST_DEST_HI) || (state_nxt == ST_DEST_LO) ||
			               (state_nxt == ST_SEC_DATA);
			EXEC_VALID <= (state_nxt == ST_RUN);
			if (sample_now) begin
				PC_ADDR <= ROM_BOOT_ADDR;
			end else if (state_nxt == ST_RUN && state_r != ST_RUN) begin
				if (state_r == ST_INIT) PC_ADDR <= CS3_VECTOR_ADDR;
				else if (state_r == ST_HOST_POLL) PC_ADDR <= HOST_ENTRY_ADDR;
				else PC_ADDR <= entry_r;
			end
			if (state_r == ST_INIT && !is_noboot && !is_host && !is_reserved) begin
				BOOT_HANDSHAKE_LINE_OE_N <= 1'h0;
			end
			if (!BOOT_HANDSHAKE_LINE_OE_N) begin
				BOOT_HANDSHAKE_LINE_OUT <= (state_nxt == ST_DELAY) ||
				                           (state_nxt == ST_RUN);
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_sampled;
		$rose(sampled_r);
	endsequence

	sequence s_noboot_start;
		s_sampled ##0 ((MODE_CODE == MODE_NOBOOT_A) || (MODE_CODE == MODE_NOBOOT_B));
	endsequence

	sequence s_reserved_start;
		s_sampled ##0 ((MODE_CODE >= MODE_RSV_FIRST) && (MODE_CODE <= MODE_RSV_LAST));
	endsequence

	AST_SAMPLE_TIME: assert property (s_sampled |-> $past(samp_cnt_r) == SAMPLE_CYCLES - 5'h01)
		else $error("mode straps not sampled 30 cycles after reset");
	AST_STRAP_MAP: assert property (s_sampled |-> MODE_CODE == $past({BOOT_SOURCE_STRAPS_BIT3,
		GP_LINE_THREE_IN, GP_LINE_TWO_IN, GP_LINE_ONE_IN}))
		else $error("mode code does not match strap pins");
	AST_MODE_HELD: assert property (sampled_r && $past(sampled_r) |-> $stable(MODE_CODE))
		else $error("latched mode code changed");
	AST_STACK_INIT: assert property (TABLE_READY |-> DATA_STACK_POINTER == DATA_STACK_INIT &&
		SYSTEM_STACK_POINTER == SYS_STACK_INIT && STACK_MODE == STACK_32_SLOW)
		else $error("stack state wrong during load");
	AST_LOAD_FLAGS: assert property (TABLE_READY |-> GLOBAL_INTERRUPT_MASK &&
		!SIGN_EXTENSION_MODE && LEGACY_COMPAT_MODE)
		else $error("status bits wrong during load");
	AST_SIGN_EXT_RESTORE: assert property ($rose(EXEC_VALID) && table_mode_r |->
		SIGN_EXTENSION_MODE && PC_ADDR == entry_r && $past(!SIGN_EXTENSION_MODE))
		else $error("sign extension or entry wrong at hand-over");
	AST_NOBOOT: assert property (s_noboot_start |-> ##1 (EXEC_VALID && !ROM_MAPPED &&
		PC_ADDR == CS3_VECTOR_ADDR))
		else $error("no-boot mode did not fetch from chip select three");
	AST_RESERVED: assert property (s_reserved_start |-> ##1 (BOOT_HALTED && !TABLE_READY)[*4])
		else $error("reserved mode did not halt");
	AST_HOST_START: assert property (state_r == ST_HOST_POLL && HOST_RESET_FLAG |=>
		EXEC_VALID && PC_ADDR == HOST_ENTRY_ADDR)
		else $error("host boot did not start at host entry");
	AST_DELAY_HS: assert property (state_r == ST_DELAY |-> BOOT_HANDSHAKE_LINE_OUT &&
		!BOOT_HANDSHAKE_LINE_OE_N)
		else $error("handshake line not high during delay");
	// a write pulse trails its take by one cycle, so look at the two takes behind it
	AST_SECTION_ADDR: assert property (MEM_WR && $past(MEM_WR) &&
		$past(state_r) == ST_SEC_DATA && $past(state_r, 2) == ST_SEC_DATA |->
		MEM_ADDR == $past(MEM_ADDR) + 24'h000001)
		else $error("section write address did not step by one");
endmodule : boot_sequencer

/* test/boot_source_model.sv */
`timescale 1ns/1ps
module boot_source_model
	import boot_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// table word stream
	input  wire logic              table_ready,
	output logic                   table_valid,
	output logic [WORD_W-1:0]      table_data
);
	logic [WORD_W-1:0] words[$];
	logic              slow;
	logic              taken;

	initial begin
		table_valid = 1'b0;
		table_data  = 16'h0000;
		slow        = 1'b0;
	end

	// a word stays offered until the edge that takes it
	always @(posedge clk) begin
		taken = (table_valid === 1'b1) && (table_ready === 1'b1);
		#1;
		if (taken)
			void'(words.pop_front());
		if (reset || words.size() == 0 || (taken && slow)) begin
			// idle data toggles so a stale word never looks valid
			table_valid = 1'b0;
			table_data  = ~table_data;
		end else begin
			table_valid = 1'b1;
			table_data  = words[0];
		end
	end
endmodule : boot_source_model

/* test/tb_boot_sequencer.sv */
`timescale 1ns/1ps
module tb_boot_sequencer
	import boot_pkg::*;
;
	localparam logic [23:0] CS3 = 24'h3a0000;
	localparam logic [15:0] TBL [13] = '{16'h0012, 16'h3456, 16'h0002, 16'h0010, 16'habcd,
		16'hffff, 16'h0014, 16'h0002, 16'h0000, 16'h0200, 16'h1111, 16'h2222, 16'h0000};
	localparam logic [39:0] EXPM [4] = '{{24'h000060, 16'h0012}, {24'h000061, 16'h3456},
		{24'h000200, 16'h1111}, {24'h000201, 16'h2222}};
	// the last two codes break the strap rule on purpose to reach the safe halt
	localparam logic [3:0] MODES [12] = '{4'h1, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf,
		4'h0, 4'h8, 4'h2, 4'h7};

	logic        clk, reset, hs_out, hs_oe_n, host_flag, tvalid, tready, rom_mapped;
	logic        int_mask, sign_ext, compat, mem_wr, port_wr, exec_valid, halted, sx_load;
	logic [3:0]  straps, mode_code;
	logic [2:0]  src_sel;
	logic [1:0]  src_opt, stack_mode;
	logic [15:0] tdata, mem_data, port_addr, port_data;
	logic [23:0] data_stack, sys_stack, mem_addr, pc;
	logic [39:0] memq[$];
	logic [31:0] portq[$];
	int          hs_cnt, cyc, fail_count, cmp_count;

	boot_sequencer #(.CS3_VECTOR_ADDR(CS3), .DELAY_W(16)) dut (
		.CLK(clk), .RESET(reset),
		.GP_LINE_ONE_IN(straps[0]), .GP_LINE_TWO_IN(straps[1]),
		.GP_LINE_THREE_IN(straps[2]), .BOOT_SOURCE_STRAPS_BIT3(straps[3]),
		.BOOT_HANDSHAKE_LINE_OUT(hs_out), .BOOT_HANDSHAKE_LINE_OE_N(hs_oe_n),
		.HOST_RESET_FLAG(host_flag), .TABLE_VALID(tvalid), .TABLE_DATA(tdata),
		.TABLE_READY(tready), .MODE_CODE(mode_code), .BOOT_SOURCE(src_sel),
		.SOURCE_OPTION(src_opt), .ROM_MAPPED(rom_mapped), .DATA_STACK_POINTER(data_stack),
		.SYSTEM_STACK_POINTER(sys_stack), .STACK_MODE(stack_mode),
		.GLOBAL_INTERRUPT_MASK(int_mask),
		.SIGN_EXTENSION_MODE(sign_ext), .LEGACY_COMPAT_MODE(compat), .MEM_WR(mem_wr),
		.MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .PORT_WR(port_wr), .PORT_ADDR(port_addr),
		.PORT_DATA(port_data), .PC_ADDR(pc), .EXEC_VALID(exec_valid), .BOOT_HALTED(halted));

	boot_source_model src (.clk(clk), .reset(reset), .table_ready(tready),
		.table_valid(tvalid), .table_data(tdata));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// record every write pulse and the delay window
	always @(posedge clk) begin
		if (mem_wr === 1'b1)
			memq.push_back({mem_addr, mem_data});
		if (port_wr === 1'b1)
			portq.push_back({port_addr, port_data});
		if (hs_out === 1'b1 && exec_valid === 1'b0) begin
			hs_cnt++;
			sx_load = sign_ext;
		end
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmp_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_flag

	function automatic logic [4:0] exp_sel(input logic [3:0] c);
		case (c)
			MODE_SPI24:                   return {SRC_SPI, OPT_SPI_ADDR24};
			MODE_SPI16:                   return {SRC_SPI, OPT_SPI_ADDR16};
			MODE_XMEM8:                   return {SRC_XMEM, OPT_WIDTH8};
			MODE_XMEM16:                  return {SRC_XMEM, OPT_WIDTH16};
			MODE_XMEM32:                  return {SRC_XMEM, OPT_WIDTH32};
			MODE_HOST:                    return {SRC_HOST, 2'h0};
			MODE_SER16:                   return {SRC_SERIAL, OPT_WIDTH16};
			MODE_SER8:                    return {SRC_SERIAL, OPT_WIDTH8};
			MODE_NOBOOT_A, MODE_NOBOOT_B: return {SRC_NONE, 2'h0};
			default:                      return {SRC_RESERVED, 2'h0};
		endcase
	endfunction : exp_sel

	task automatic run(input logic [3:0] code);
		int   i;
		logic tbl;
		logic [4:0] sel;
		tbl = code inside {4'h1, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
		sel = exp_sel(code);
		memq.delete();
		portq.delete();
		hs_cnt    = 0;
		sx_load   = 1'b1;
		host_flag = 1'b0;
		straps    = code;
		reset     = 1'b1;
		src.slow  = code[0];
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		if (tbl)
			foreach (TBL[k])
				src.words.push_back(TBL[k]);
		repeat (32) @(posedge clk);
		// straps move after sampling; the latched code must not
		#1 straps = ~code;
		if (code == MODE_HOST) begin
			repeat (20) @(posedge clk);
			#1 cmp_flag(exec_valid, 1'b0);
			host_flag = 1'b1;
		end
		for (i = 0; i < 1000 && exec_valid !== 1'b1 && halted !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		cmp(mode_code, code);
		cmp(src_sel, sel[4:2]);
		if (code == MODE_NOBOOT_A || code == MODE_NOBOOT_B) begin
			cmp(pc, CS3);
			cmp_flag(rom_mapped, 1'b0);
			cmp_flag(exec_valid, 1'b1);
			return;
		end
		cmp({data_stack, sys_stack}, {DATA_STACK_INIT, SYS_STACK_INIT});
		cmp({stack_mode, int_mask, compat}, {STACK_32_SLOW, 2'b11});
		if (code inside {[MODE_RSV_FIRST:MODE_RSV_LAST]}) begin
			repeat (50) @(posedge clk);
			#1 cmp_flag(halted, 1'b1);
			cmp({exec_valid, tready}, 2'b00);
			cmp(memq.size(), 0);
			return;
		end
		cmp_flag(exec_valid, 1'b1);
		cmp_flag(sign_ext, 1'b1);
		cmp_flag(rom_mapped, 1'b1);
		if (code == MODE_HOST) begin
			cmp(pc, HOST_ENTRY_ADDR);
			return;
		end
		cmp(src_opt, sel[1:0]);
		cmp(pc, 24'h123456);
		cmp(memq.size(), 4);
		if (memq.size() == 4)
			foreach (EXPM[k])
				cmp(memq[k], EXPM[k]);
		cmp(portq.size(), 1);
		if (portq.size() == 1)
			cmp(portq[0], {16'h0010, 16'habcd});
		cmp_flag(hs_cnt >= 20 && hs_cnt <= 24, 1'b1);
		cmp_flag(sx_load, 1'b0);
		cmp({hs_oe_n, hs_out}, 2'b01);
	endtask : run

	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		reset      = 1'b1;
		straps     = 4'h0;
		host_flag  = 1'b0;
		fail_count = 0;
		cmp_count  = 0;
		cyc        = 0;
		@(posedge clk);
		#1;
		foreach (MODES[m])
			run(MODES[m]);
		report_and_stop();
	end
endmodule : tb_boot_sequencer
